// *** rtl/sch_pkg.sv ***
// Package: command codes, return values, nonvolatile layout and timing for the supply command handler
package sch_pkg;
  // Command identifier bytes
  localparam logic [7:0] SCH_PREFIX = 8'h1E;
  localparam logic [7:0] SCH_GRP_CTL = 8'h08;
  localparam logic [7:0] SCH_GRP_SYS = 8'h09;
  localparam logic [15:0] SCH_OUTPUT_ENABLE_CMD = 16'h1C00;
  localparam logic [15:0] SCH_OUTPUT_DISABLE_CMD = 16'h1C01;
  localparam logic [15:0] SCH_PROTECT_LATCH_CLEAR_CMD = 16'h1E1F;
  localparam logic [15:0] SCH_FACTORY_RESTORE_CMD = 16'h011F;
  localparam logic [15:0] SCH_SETTINGS_SAVE_CMD = 16'h0010;
  localparam logic [15:0] SCH_VOLTAGE_SETPOINT_QUERY_CMD = 16'h1B00;
  localparam logic [15:0] SCH_CURRENT_SETPOINT_QUERY_CMD = 16'h1A00;
  // Return values
  localparam logic [15:0] SCH_RET_ONE = 16'h0001;
  localparam logic [15:0] SCH_RET_ZERO = 16'h0000;
  // Setpoint scaling: volts = mv/1000, amps = code/100
  localparam int SCH_MV_PER_VOLT = 1000;
  localparam int SCH_CODE_PER_AMP = 100;
  // Nonvolatile write hold-up time
  localparam int SCH_NV_HOLD_S = 5;
  localparam int SCH_CLK_HZ = 10000000;
  localparam int SCH_NV_HOLD_CYC = SCH_NV_HOLD_S * SCH_CLK_HZ;
  // Default settings image
  localparam logic [15:0] SCH_VSET_RST = 16'h0000;
  localparam logic [15:0] SCH_ISET_RST = 16'h0000;

  typedef struct packed {
    logic [7:0] prefix;
    logic [7:0] group;
    logic [15:0] code;
  } sch_cmd_t;

  typedef struct packed {
    logic [15:0] vset_mv;
    logic [15:0] iset_10ma;
  } sch_settings_t;

  typedef struct packed {
    logic valid;
    logic known;
    logic [15:0] value;
  } sch_reply_t;
endpackage

// *** rtl/sch_nv_image.sv ***
// Nonvolatile settings image with save, factory-restore flag and power-up reload
`timescale 1ns/1ps
module sch_nv_image
  import sch_pkg::*;
#(
  parameter int HOLD_CYC = SCH_NV_HOLD_CYC
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // Requests
  input wire logic save_in,
  input wire logic restore_in,
  input wire sch_settings_t live_in,
  // Image and state
  output sch_settings_t image_out,
  output logic image_user_out,
  output logic busy_out
);
  sch_settings_t user_q, user_d;
  logic user_valid_q, user_valid_d;
  logic [31:0] hold_q, hold_d;

  always_comb begin
    user_d = user_q;
    user_valid_d = user_valid_q;
    hold_d = (hold_q != 32'h0000_0000) ? hold_q - 32'h0000_0001 : hold_q;
    if (restore_in) begin
      user_valid_d = 1'b0;
      hold_d = 32'(HOLD_CYC);
    end else if (save_in) begin
      user_d = live_in;
      user_valid_d = 1'b1;
      hold_d = 32'(HOLD_CYC);
    end
    // Write window dies with the power; the image does not
    if (reset_in) begin
      hold_d = 32'h0000_0000;
    end
  end

  // Image survives reset_in, which models input power-up
  always_ff @(posedge mclk_in) begin
    user_q <= user_d;
    user_valid_q <= user_valid_d;
    hold_q <= hold_d;
  end

  assign image_out = user_q;
  assign image_user_out = user_valid_q;
  assign busy_out = (hold_q != 32'h0000_0000);
endmodule

// *** rtl/sch_handler.sv ***
// Top: control, system and read command execution for the supply
`timescale 1ns/1ps
module sch_handler
  import sch_pkg::*;
#(
  parameter int HOLD_CYC = SCH_NV_HOLD_CYC
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // Command from frame layer
  input wire logic cmd_valid_in,
  input wire sch_cmd_t cmd_in,
  // Live setpoints and protection state
  input wire logic [15:0] vset_live_mv_in,
  input wire logic [15:0] iset_live_10ma_in,
  input wire logic protect_trip_in,
  input wire logic remote_onoff_terminal_off_in,
  // Reply to reply builder
  output sch_reply_t reply_out,
  // Supply control
  output logic output_on_out,
  output logic protect_latched_out,
  output logic [15:0] boot_vset_mv_out,
  output logic [15:0] boot_iset_10ma_out,
  output logic boot_user_out,
  output logic nv_busy_out
);
  //--------------------------------------------------
  // Decode
  //--------------------------------------------------
  logic is_ctl;
  logic is_sys;
  logic c_on;
  logic c_off;
  logic c_clr;
  logic c_rst;
  logic c_save;
  logic c_vq;
  logic c_iq;
  logic save_p;
  logic restore_p;
  sch_settings_t live;
  sch_settings_t image;
  logic image_user;
  logic nv_busy;

  assign is_ctl = cmd_valid_in && cmd_in.prefix == SCH_PREFIX && cmd_in.group == SCH_GRP_CTL;
  assign is_sys = cmd_valid_in && cmd_in.prefix == SCH_PREFIX && cmd_in.group == SCH_GRP_SYS;
  assign c_on = is_ctl && cmd_in.code == SCH_OUTPUT_ENABLE_CMD;
  assign c_off = is_ctl && cmd_in.code == SCH_OUTPUT_DISABLE_CMD;
  assign c_clr = is_ctl && cmd_in.code == SCH_PROTECT_LATCH_CLEAR_CMD;
  assign c_rst = is_sys && cmd_in.code == SCH_FACTORY_RESTORE_CMD;
  assign c_save = is_sys && cmd_in.code == SCH_SETTINGS_SAVE_CMD;
  assign c_vq = is_sys && cmd_in.code == SCH_VOLTAGE_SETPOINT_QUERY_CMD;
  assign c_iq = is_sys && cmd_in.code == SCH_CURRENT_SETPOINT_QUERY_CMD;
  assign save_p = c_save;
  assign restore_p = c_rst;
  // Raw codes: millivolts and ten-milliamp units
  assign live.vset_mv = vset_live_mv_in;
  assign live.iset_10ma = iset_live_10ma_in;

  //--------------------------------------------------
  // Nonvolatile image
  //--------------------------------------------------
  sch_nv_image #(
    .HOLD_CYC(HOLD_CYC)
  ) u_nv (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .save_in(save_p),
    .restore_in(restore_p),
    .live_in(live),
    .image_out(image),
    .image_user_out(image_user),
    .busy_out(nv_busy)
  );

  //--------------------------------------------------
  // Output and latch state
  //--------------------------------------------------
  logic on_q;
  logic on_d;
  logic latch_q;
  logic latch_d;
  logic out_on_q;
  logic out_on_d;

  always_comb begin
    on_d = on_q;
    latch_d = latch_q;
    if (c_off) begin
      on_d = 1'b0;
    end else if (c_on && !remote_onoff_terminal_off_in) begin
      on_d = 1'b1;
    end
    // Terminal off drops the on flag
    if (remote_onoff_terminal_off_in) begin
      on_d = 1'b0;
    end
    // Trip wins over a simultaneous clear
    if (protect_trip_in) begin
      latch_d = 1'b1;
    end else if (c_clr) begin
      latch_d = 1'b0;
    end
    // Power-up: output off, no latched stop
    if (reset_in) begin
      on_d = 1'b0;
      latch_d = 1'b0;
    end
    // Pin follows the next flags, so it lands with them
    out_on_d = on_d && !latch_d;
  end

  always_ff @(posedge mclk_in) begin
    on_q <= on_d;
    latch_q <= latch_d;
    out_on_q <= out_on_d;
  end

  //--------------------------------------------------
  // Reply
  //--------------------------------------------------
  sch_reply_t reply_q;
  sch_reply_t reply_d;

  always_comb begin
    reply_d.valid = cmd_valid_in;
    reply_d.known = c_on | c_off | c_clr | c_rst | c_save | c_vq | c_iq;
    reply_d.value = SCH_RET_ZERO;
    if (c_on || c_save) begin
      reply_d.value = SCH_RET_ONE;
    end else if (c_vq) begin
      reply_d.value = vset_live_mv_in;
    end else if (c_iq) begin
      reply_d.value = iset_live_10ma_in;
    end
    // Nothing answers during power-up
    if (reset_in) begin
      reply_d = '0;
    end
  end

  always_ff @(posedge mclk_in) begin
    reply_q <= reply_d;
  end

  //--------------------------------------------------
  // Power-up setpoints
  //--------------------------------------------------
  logic [15:0] bv_q;
  logic [15:0] bv_d;
  logic [15:0] bi_q;
  logic [15:0] bi_d;
  logic bu_q;
  logic bu_d;

  always_comb begin
    bv_d = bv_q;
    bi_d = bi_q;
    bu_d = bu_q;
    if (reset_in) begin
      // Restored or saved image applied only at power-up
      bu_d = image_user;
      bv_d = image_user ? image.vset_mv : SCH_VSET_RST;
      bi_d = image_user ? image.iset_10ma : SCH_ISET_RST;
    end
  end

  // Boot values load during reset, held thereafter
  always_ff @(posedge mclk_in) begin
    bv_q <= bv_d;
    bi_q <= bi_d;
    bu_q <= bu_d;
  end

  //--------------------------------------------------
  // Write-hold status
  //--------------------------------------------------
  logic busy_q;
  logic busy_d;

  always_comb begin
    busy_d = nv_busy;
    if (reset_in) begin
      busy_d = 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    busy_q <= busy_d;
  end

  //--------------------------------------------------
  // Outputs
  //--------------------------------------------------
  assign reply_out = reply_q;
  assign output_on_out = out_on_q;
  assign protect_latched_out = latch_q;
  assign boot_vset_mv_out = bv_q;
  assign boot_iset_10ma_out = bi_q;
  assign boot_user_out = bu_q;
  assign nv_busy_out = busy_q;
endmodule

// *** bench/sch_handler_checker.sv ***
// Checker: port-level assertions for the supply command handler
`timescale 1ns/1ps
module sch_handler_checker
  import sch_pkg::*;
(
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic cmd_valid_in,
  input wire sch_cmd_t cmd_in,
  input wire logic [15:0] vset_live_mv_in,
  input wire logic [15:0] iset_live_10ma_in,
  input wire logic protect_trip_in,
  input wire logic remote_onoff_terminal_off_in,
  input wire sch_reply_t reply_out,
  input wire logic output_on_out,
  input wire logic protect_latched_out
);
  logic ctl;
  logic sys;
  assign ctl = cmd_valid_in && cmd_in[31:16] == {SCH_PREFIX, SCH_GRP_CTL};
  assign sys = cmd_valid_in && cmd_in[31:16] == {SCH_PREFIX, SCH_GRP_SYS};
  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  chk_reply_once: assert property (cmd_valid_in |=> reply_out.valid)
    else $error("missing reply");
  chk_reply_idle: assert property (!cmd_valid_in |=> !reply_out.valid)
    else $error("stray reply");
  chk_enable_on: assert property (ctl && cmd_in.code == SCH_OUTPUT_ENABLE_CMD && !remote_onoff_terminal_off_in
    && !protect_trip_in && !protect_latched_out |=> output_on_out && reply_out.value == SCH_RET_ONE)
    else $error("enable failed");
  chk_enable_held: assert property (ctl && cmd_in.code == SCH_OUTPUT_ENABLE_CMD && remote_onoff_terminal_off_in
    |=> !output_on_out && reply_out.value == SCH_RET_ONE) else $error("enable passed terminal");
  chk_disable_off: assert property (ctl && cmd_in.code == SCH_OUTPUT_DISABLE_CMD
    |=> !output_on_out && reply_out.value == SCH_RET_ZERO) else $error("disable failed");
  chk_latch_clear: assert property (ctl && cmd_in.code == SCH_PROTECT_LATCH_CLEAR_CMD && !protect_trip_in
    |=> !protect_latched_out && reply_out.value == SCH_RET_ZERO) else $error("clear failed");
  chk_trip_stop: assert property (protect_trip_in |=> protect_latched_out && !output_on_out)
    else $error("trip not latched");
  chk_save_ret: assert property (sys && cmd_in.code == SCH_SETTINGS_SAVE_CMD |=> reply_out.value == SCH_RET_ONE)
    else $error("save reply");
  chk_restore_ret: assert property (sys && cmd_in.code == SCH_FACTORY_RESTORE_CMD
    |=> reply_out.value == SCH_RET_ZERO) else $error("restore reply");
  chk_volt_query: assert property (sys && cmd_in.code == SCH_VOLTAGE_SETPOINT_QUERY_CMD
    |=> reply_out.value == $past(vset_live_mv_in)) else $error("voltage reply");
  chk_curr_query: assert property (sys && cmd_in.code == SCH_CURRENT_SETPOINT_QUERY_CMD
    |=> reply_out.value == $past(iset_live_10ma_in)) else $error("current reply");
  cov_on: cover property (output_on_out);
  cov_latch: cover property (protect_latched_out);
  cov_held: cover property (ctl && remote_onoff_terminal_off_in);
endmodule
bind sch_handler sch_handler_checker chk_u (
  .mclk_in(mclk_in),
  .reset_in(reset_in),
  .cmd_valid_in(cmd_valid_in),
  .cmd_in(cmd_in),
  .vset_live_mv_in(vset_live_mv_in),
  .iset_live_10ma_in(iset_live_10ma_in),
  .protect_trip_in(protect_trip_in),
  .remote_onoff_terminal_off_in(remote_onoff_terminal_off_in),
  .reply_out(reply_out),
  .output_on_out(output_on_out),
  .protect_latched_out(protect_latched_out)
);

// *** bench/sch_host_model.sv ***
// Host model: issues one command at a time and collects its reply
`timescale 1ns/1ps
module sch_host_model
  import sch_pkg::*;
(
  input wire logic mclk_in,
  input wire sch_reply_t reply_in,
  output logic cmd_valid_out,
  output sch_cmd_t cmd_out
);
  initial begin
    cmd_valid_out = 1'b0;
    cmd_out = '0;
  end
  // One command, one reply
  task automatic send(input logic [7:0] grp, input logic [15:0] code, output sch_reply_t r);
    @(posedge mclk_in);
    #1 cmd_valid_out = 1'b1;
    cmd_out = {SCH_PREFIX, grp, code};
    @(posedge mclk_in);
    #1 cmd_valid_out = 1'b0;
    cmd_out = ~cmd_out;
    r = reply_in;
  endtask
  // Keep power up while the write completes
  task automatic nv_wait(input int cyc);
    repeat (cyc) @(posedge mclk_in);
  endtask
endmodule

// *** bench/testbench.sv ***
// Testbench: directed scenarios for the supply command handler
`timescale 1ns/1ps
module testbench
  import sch_pkg::*;
;
  localparam int HOLD = 20;
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic cmd_valid;
  sch_cmd_t cmd;
  logic [15:0] vset = 16'h1388, iset = 16'h0546, bv, bi;
  logic trip = 1'b0, roff = 1'b0, on, latched, buser, busy;
  sch_reply_t reply, r;
  int n_fail = 0, cmp_count = 0, cycles = 0;
  always #50 mclk_in = ~mclk_in;
  sch_handler #(.HOLD_CYC(HOLD)) dut_u (.mclk_in(mclk_in), .reset_in(reset_in), .cmd_valid_in(cmd_valid),
    .cmd_in(cmd), .vset_live_mv_in(vset), .iset_live_10ma_in(iset), .protect_trip_in(trip),
    .remote_onoff_terminal_off_in(roff), .reply_out(reply), .output_on_out(on), .protect_latched_out(latched),
    .boot_vset_mv_out(bv), .boot_iset_10ma_out(bi), .boot_user_out(buser), .nv_busy_out(busy));
  sch_host_model host_u (.mclk_in(mclk_in), .reply_in(reply), .cmd_valid_out(cmd_valid), .cmd_out(cmd));
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic power_cycle();
    host_u.nv_wait(HOLD + 5);
    #1 chk(busy, 1'b0, "busy after hold");
    reset_in = 1'b1;
    repeat (2) @(posedge mclk_in);
    #1 reset_in = 1'b0;
  endtask
  task automatic t_onoff();
    host_u.send(SCH_GRP_CTL, SCH_OUTPUT_ENABLE_CMD, r);
    chk({on, r.value}, {1'b1, SCH_RET_ONE}, "enable");
    roff = 1'b1;
    host_u.send(SCH_GRP_CTL, SCH_OUTPUT_ENABLE_CMD, r);
    chk({on, r.value}, {1'b0, SCH_RET_ONE}, "terminal hold");
    roff = 1'b0;
    host_u.send(SCH_GRP_CTL, SCH_OUTPUT_ENABLE_CMD, r);
    host_u.send(SCH_GRP_CTL, SCH_OUTPUT_DISABLE_CMD, r);
    chk({on, r.value}, {1'b0, SCH_RET_ZERO}, "disable");
    $display("test onoff done");
  endtask
  task automatic t_latch();
    host_u.send(SCH_GRP_CTL, SCH_OUTPUT_ENABLE_CMD, r);
    trip = 1'b1;
    @(posedge mclk_in);
    #1 trip = 1'b0;
    chk({latched, on}, 2'b10, "trip stop");
    // Clear only once the fault is gone
    host_u.send(SCH_GRP_CTL, SCH_PROTECT_LATCH_CLEAR_CMD, r);
    chk({latched, on, r.value}, {2'b01, SCH_RET_ZERO}, "latch clear");
    $display("test latch done");
  endtask
  task automatic t_query();
    vset = 16'h2710;
    host_u.send(SCH_GRP_SYS, SCH_VOLTAGE_SETPOINT_QUERY_CMD, r);
    chk(r, {2'b11, 16'h2710}, "vref");
    vset = 16'h27D8;
    host_u.send(SCH_GRP_SYS, SCH_VOLTAGE_SETPOINT_QUERY_CMD, r);
    chk(r.value, 16'h27D8, "vref trim");
    iset = 16'h0FA0;
    host_u.send(SCH_GRP_SYS, SCH_CURRENT_SETPOINT_QUERY_CMD, r);
    chk(r.value, 16'h0FA0, "iref");
    iset = 16'h07D0;
    host_u.send(SCH_GRP_SYS, SCH_CURRENT_SETPOINT_QUERY_CMD, r);
    chk(r.value, 16'h07D0, "iref protect");
    host_u.send(SCH_GRP_CTL, 16'h1C02, r);
    chk(r, {2'b10, 16'h0000}, "unknown code");
    $display("test query done");
  endtask
  task automatic t_nv();
    host_u.send(SCH_GRP_SYS, SCH_SETTINGS_SAVE_CMD, r);
    chk(r.value, SCH_RET_ONE, "save reply");
    @(posedge mclk_in);
    #1 chk(busy, 1'b1, "save busy");
    vset = 16'h1111;
    iset = 16'h0222;
    power_cycle();
    chk({buser, bv, bi}, {1'b1, 16'h27D8, 16'h07D0}, "saved boot");
    host_u.send(SCH_GRP_SYS, SCH_FACTORY_RESTORE_CMD, r);
    chk({buser, bv, r.value}, {1'b1, 16'h27D8, SCH_RET_ZERO}, "restore live");
    power_cycle();
    chk({buser, bv, bi}, {1'b0, SCH_VSET_RST, SCH_ISET_RST}, "factory boot");
    $display("test nv done");
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      wrap_up();
    end
  end
  initial begin
    repeat (2) @(posedge mclk_in);
    #1 reset_in = 1'b0;
    host_u.send(SCH_GRP_SYS, SCH_FACTORY_RESTORE_CMD, r);
    power_cycle();
    t_onoff();
    t_latch();
    t_query();
    t_nv();
    wrap_up();
  end
endmodule
